// file: hw/usie_sie.sv
// Full-speed USB serial interface engine: line coding, CRC, tokens, handshakes
`timescale 1ns/1ps
`include "usie_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Full-speed function, one port, one address
// - Nine endpoints; endpoint 0 is control
// - Endpoints 1-8 each configurable IN or OUT
// - NRZI decode, bit unstuff, encode, bit stuff
// - Append CRC16; bad-CRC packets get no handshake, but their payload bytes still reach SRAM
// - Ignore tokens for other device addresses; data payload after them still reaches SRAM
// - Flag SETUP, IN or OUT token types
// - Detect SOF and store frame number
// - Dedicated 512-byte USB payload SRAM
// - Payload reaches SRAM only via arbiter
// - Requires 24 MHz system clock
module usie_sie #(
   parameter int NUM_EP  = `USIE_NUM_EP,
   parameter int CLK_HZ  = `USIE_SYS_CLK_HZ
) (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    arst_n_i,
   // Line, receiver outputs and driver
   input  wire logic                    dp_i,
   input  wire logic                    dm_i,
   output logic                         dp_o,
   output logic                         dm_o,
   output logic                         line_oe_o,
   // Configuration
   input  wire logic [6:0]              dev_addr_i,
   input  wire logic [NUM_EP-1:0]       ep_is_in_i,
   input  wire logic [NUM_EP-1:0]       ep_ready_i,
   input  wire logic [NUM_EP-1:0]       ep_stall_i,
   input  wire logic [6:0]              ep_tx_len_i,
   // Token, frame and receive status
   output usie_pkg::usie_token_t        token_o,
   output logic                         token_pulse_o,
   output logic [10:0]                  frame_o,
   output logic                         sof_pulse_o,
   output logic [6:0]                   rx_len_o,
   output logic                         rx_done_o,
   // Arbiter port to the USB SRAM
   output usie_pkg::usie_ram_req_t      ram_req_o,
   output logic                         ram_req_valid_o,
   input  wire logic                    ram_grant_i,
   input  wire logic [7:0]              ram_rdata_i
);
   import usie_pkg::*;
   // Two samples per 12 Mb/s bit at 24 MHz; other clocks break the bit timing
   localparam int HALF = CLK_HZ / `USIE_BIT_RATE_HZ / `USIE_SAMPLES_PER_BIT;
   //////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] crc5(input logic [4:0] c, input logic b);
      crc5 = {c[3:0], 1'b0} ^ ((c[4] ^ b) ? 5'h05 : 5'h00);
   endfunction
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic b);
      crc16 = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h8005 : 16'h0000);
   endfunction
   // The line is sent LSB first, so the CRC register is mirrored before loading
   function automatic logic [15:0] rev16(input logic [15:0] v);
      for (int i = 0; i < 16; i++)
         rev16[i] = v[15 - i];
   endfunction
   //////////////////////////////////////////////////////////////////////////
   usie_state_t st_reg;
   logic        ph_reg;
   logic        last_reg;
   logic [2:0]  ones_reg;
   logic [7:0]  sh_reg;
   logic [2:0]  bit_reg;
   logic [7:0]  nbyte_reg;
   logic [3:0]  pid_reg;
   logic [15:0] tok_reg;
   logic [4:0]  c5_reg;
   logic [15:0] c16_reg;
   logic [3:0]  ep_reg;
   logic        tok_in_reg;
   logic [31:0] txsh_reg;
   logic [5:0]  txn_reg;
   logic        txcrc_reg;
   logic [6:0]  txidx_reg;
   logic [6:0]  txlen_reg;
   logic [1:0]  eop_reg;
   logic        se0_reg;
   logic [15:0] hist_reg;
   logic        q_valid;
   logic [16:0] q_word;
   wire         se0      = ~dp_i & ~dm_i;
   wire         tick     = ph_reg;
   wire         rx_bit   = ~(dp_i ^ last_reg);
   wire         stuffed  = (ones_reg == 3'd6);
   wire         byte_end = tick & ~stuffed & (bit_reg == 3'd7) & (st_reg == USIE_RX);
   wire [7:0]   rx_byte  = {rx_bit, sh_reg[7:1]};
   wire [3:0]   tok_ep   = {tok_reg[2:0], tok_reg[15]};
   wire [6:0]   tok_addr = tok_reg[14:8];
   wire         is_token = (pid_reg == `USIE_PID_SETUP) | (pid_reg == `USIE_PID_IN) |
                           (pid_reg == `USIE_PID_OUT);
   wire         is_data  = (pid_reg == `USIE_PID_DATA0) | (pid_reg == `USIE_PID_DATA1);
   wire         tok_ok   = (nbyte_reg == 8'd4) & (c5_reg == `USIE_CRC5_RES);
   wire         data_ok  = is_data & (c16_reg == `USIE_CRC16_RES) & ~tok_in_reg;
   wire         addr_hit = (tok_addr == dev_addr_i);
   wire         ep_valid = (tok_ep < 4'(NUM_EP));
   // Endpoint 0 takes both directions; the others only the configured one
   wire         dir_ok   = (tok_ep == 4'd0) | (ep_is_in_i[tok_ep] == (pid_reg == `USIE_PID_IN));
   // A token's endpoint reaches ep_reg only one cycle after it is decoded
   wire [3:0]   hs_ep    = (st_reg == USIE_DEC && is_token) ? tok_ep : ep_reg;
   wire [3:0]   hs_pid   = ep_stall_i[hs_ep] ? `USIE_PID_STALL :
                           ep_ready_i[hs_ep] ? `USIE_PID_ACK : `USIE_PID_NAK;
   wire [8:0]   ram_base = {ep_reg, 5'b0_0000} + {ep_reg, 5'b0_0000};
   wire         tx_byte_need = (txn_reg == 6'd0) & (txidx_reg < txlen_reg) & ~txcrc_reg;
   // Writes trail the line by two bytes, so the CRC bytes never reach the SRAM
   wire         rx_wr      = byte_end & (nbyte_reg >= 8'd4) & is_data;
   wire [16:0]  rx_wr_word = {ram_base + 9'(nbyte_reg - 8'd4), hist_reg[15:8]};
   usie_fifo #(
      .WIDTH (17),
      .DEPTH (4)
   ) rx_q_u (
      .clock_i     (clock_i),
      .arst_n_i    (arst_n_i),
      .flush_i     (1'b0),
      .in_valid_i  (rx_wr),
      .in_ready_o  (),
      .in_data_i   (rx_wr_word),
      .out_valid_o (q_valid),
      .out_ready_i (ram_grant_i),
      .out_data_o  (q_word)
   );
   assign ram_req_valid_o = q_valid | ((st_reg == USIE_TX) & tx_byte_need);
   assign ram_req_o.we    = q_valid;
   assign ram_req_o.addr  = q_valid ? q_word[16:8] : ram_base + {2'b00, txidx_reg};
   assign ram_req_o.wdata = q_word[7:0];
   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_reg <= USIE_IDLE; ph_reg <= 1'b0; last_reg <= 1'b1; ones_reg <= '0;
         sh_reg <= '0; bit_reg <= '0; nbyte_reg <= '0; pid_reg <= '0; tok_reg <= '0;
         c5_reg <= '1; c16_reg <= '1; ep_reg <= '0; tok_in_reg <= 1'b1;
         hist_reg <= '0;
         txsh_reg <= '0; txn_reg <= '0; txcrc_reg <= 1'b0; txidx_reg <= '0;
         txlen_reg <= '0; eop_reg <= '0; se0_reg <= 1'b0;
         dp_o <= 1'b1; dm_o <= 1'b0; line_oe_o <= 1'b0;
         token_o <= '0; token_pulse_o <= 1'b0; frame_o <= '0; sof_pulse_o <= 1'b0;
         rx_len_o <= '0; rx_done_o <= 1'b0;
      end
      else
      begin
         ph_reg <= (st_reg == USIE_IDLE) ? 1'b1 : ~ph_reg;
         token_pulse_o <= 1'b0;
         sof_pulse_o <= 1'b0;
         rx_done_o <= 1'b0;
         se0_reg <= se0;
         case (st_reg)
            USIE_IDLE:
            begin
               line_oe_o <= 1'b0;
               last_reg <= 1'b1;
               ones_reg <= '0; bit_reg <= '0; nbyte_reg <= '0;
               c5_reg <= '1; c16_reg <= '1;
               if (~dp_i & dm_i)
                  st_reg <= USIE_RX;
            end
            USIE_RX:
            begin
               if (se0 & se0_reg)
                  st_reg <= USIE_DEC;
               else if (tick)
               begin
                  last_reg <= dp_i;
                  ones_reg <= rx_bit ? ones_reg + 3'd1 : 3'd0;
                  if (!stuffed)
                  begin
                     sh_reg <= rx_byte;
                     bit_reg <= bit_reg + 3'd1;
                     if (nbyte_reg > 8'd1)
                     begin
                        c5_reg <= crc5(c5_reg, rx_bit);
                        c16_reg <= crc16(c16_reg, rx_bit);
                     end
                     if (byte_end)
                     begin
                        nbyte_reg <= nbyte_reg + 8'd1;
                        hist_reg <= {hist_reg[7:0], rx_byte};
                        if (nbyte_reg == 8'd1)
                           pid_reg <= rx_byte[3:0];
                        if (nbyte_reg == 8'd2)
                           tok_reg[15:8] <= rx_byte;
                        if (nbyte_reg == 8'd3)
                           tok_reg[7:0] <= rx_byte;
                     end
                  end
               end
            end
            USIE_DEC:
            begin
               st_reg <= USIE_IDLE;
               // Data is acknowledged only right after our own OUT or SETUP token; SRAM writes are not gated by this
               tok_in_reg <= 1'b1;
               if (is_token & tok_ok & addr_hit & ep_valid & dir_ok)
               begin
                  ep_reg <= tok_ep;
                  tok_in_reg <= (pid_reg == `USIE_PID_IN);
                  token_o.setup <= (pid_reg == `USIE_PID_SETUP);
                  token_o.in    <= (pid_reg == `USIE_PID_IN);
                  token_o.out   <= (pid_reg == `USIE_PID_OUT);
                  token_o.ep    <= tok_ep;
                  token_pulse_o <= 1'b1;
                  if (pid_reg == `USIE_PID_IN)
                  begin
                     txsh_reg[15:0] <= ep_ready_i[tok_ep] & ~ep_stall_i[tok_ep] ?
                        {~`USIE_PID_DATA0, `USIE_PID_DATA0, `USIE_SYNC} :
                        {~hs_pid, hs_pid, `USIE_SYNC};
                     txlen_reg <= (ep_ready_i[tok_ep] & ~ep_stall_i[tok_ep]) ? ep_tx_len_i : '0;
                     txcrc_reg <= ~(ep_ready_i[tok_ep] & ~ep_stall_i[tok_ep]);
                     st_reg <= USIE_TXGO;
                  end
               end
               else if (pid_reg == `USIE_PID_SOF & tok_ok)
               begin
                  frame_o <= {tok_reg[2:0], tok_reg[15:8]};
                  sof_pulse_o <= 1'b1;
               end
               else if (data_ok)
               begin
                  rx_len_o <= 7'(nbyte_reg - 8'd4);
                  rx_done_o <= 1'b1;
                  txsh_reg[15:0] <= {~hs_pid, hs_pid, `USIE_SYNC};
                  txlen_reg <= '0;
                  txcrc_reg <= 1'b1;
                  st_reg <= USIE_TXGO;
               end
            end
            USIE_TXGO:
            begin
               txn_reg <= 6'd16; txidx_reg <= '0; c16_reg <= '1;
               ones_reg <= '0; last_reg <= 1'b1; line_oe_o <= 1'b1;
               st_reg <= USIE_TX;
            end
            USIE_TX:
            begin
               if (tx_byte_need)
               begin
                  if (ram_grant_i & ~q_valid)
                  begin
                     txsh_reg[7:0] <= ram_rdata_i;
                     txn_reg <= 6'd8;
                     txidx_reg <= txidx_reg + 7'd1;
                  end
               end
               else if (txn_reg == 6'd0 && !txcrc_reg)
               begin
                  // Payload done: inverted CRC16 goes out high-order bit first
                  txsh_reg[15:0] <= rev16(~c16_reg);
                  txn_reg <= 6'd16;
                  txcrc_reg <= 1'b1;
               end
               else if (txn_reg == 6'd0 && ones_reg != 3'd6)
               begin
                  eop_reg <= '0;
                  st_reg <= USIE_EOP;
               end
               else if (tick)
               begin
                  // Stuff a zero after six ones before sending the next data bit
                  if (ones_reg == 3'd6)
                  begin
                     last_reg <= ~last_reg; dp_o <= ~last_reg; dm_o <= last_reg;
                     ones_reg <= '0;
                  end
                  else
                  begin
                     if (txsh_reg[0])
                        ones_reg <= ones_reg + 3'd1;
                     else
                     begin
                        ones_reg <= '0;
                        last_reg <= ~last_reg;
                     end
                     dp_o <= txsh_reg[0] ? last_reg : ~last_reg;
                     dm_o <= txsh_reg[0] ? ~last_reg : last_reg;
                     // Only payload bits feed the CRC; header has txidx_reg at 0
                     if (!txcrc_reg && txidx_reg != 7'd0)
                        c16_reg <= crc16(c16_reg, txsh_reg[0]);
                     txsh_reg <= {1'b0, txsh_reg[31:1]};
                     txn_reg <= txn_reg - 6'd1;
                  end
               end
            end
            USIE_EOP:
            begin
               if (tick)
               begin
                  eop_reg <= eop_reg + 2'd1;
                  dp_o <= (eop_reg == 2'd2);
                  dm_o <= 1'b0;
                  if (eop_reg == 2'd2)
                     st_reg <= USIE_WAIT;
               end
            end
            USIE_WAIT:
            begin
               line_oe_o <= 1'b0;
               st_reg <= USIE_IDLE;
            end
            default:
               st_reg <= USIE_IDLE;
         endcase
      end
   end
endmodule

// file: hw/usie_consts.svh
// Constants for the full-speed USB serial interface engine
`ifndef USIE_CONSTS_SVH
`define USIE_CONSTS_SVH
`define USIE_SYS_CLK_HZ    24000000
`define USIE_BIT_RATE_HZ   12000000
`define USIE_SAMPLES_PER_BIT 2
`define USIE_NUM_EP        9
`define USIE_RAM_BYTES     512
`define USIE_EP_BYTES      64
`define USIE_PID_OUT       4'h1
`define USIE_PID_IN        4'h9
`define USIE_PID_SOF       4'h5
`define USIE_PID_SETUP     4'hD
`define USIE_PID_DATA0     4'h3
`define USIE_PID_DATA1     4'hB
`define USIE_PID_ACK       4'h2
`define USIE_PID_NAK       4'hA
`define USIE_PID_STALL     4'hE
`define USIE_CRC5_RES      5'h0C
`define USIE_CRC16_RES     16'h800D
`define USIE_SYNC          8'h80
`endif

// file: hw/usie_pkg.sv
// Types shared by the USB serial interface engine
package usie_pkg;
   typedef enum logic [3:0] {
      USIE_IDLE  = 4'b0000,
      USIE_RX    = 4'b0001,
      USIE_DEC   = 4'b0010,
      USIE_TXGO  = 4'b0011,
      USIE_TX    = 4'b0100,
      USIE_EOP   = 4'b0101,
      USIE_WAIT  = 4'b0110
   } usie_state_t;
   typedef struct packed {
      logic       we;
      logic [8:0] addr;
      logic [7:0] wdata;
   } usie_ram_req_t;
   typedef struct packed {
      logic setup;
      logic in;
      logic out;
      logic [3:0] ep;
   } usie_token_t;
endpackage

// file: hw/usie_fifo.sv
// Small valid/ready FIFO for received payload bytes
`timescale 1ns/1ps
module usie_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             arst_n_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   wire              push = in_valid_i & in_ready_o;
   wire              pop  = out_valid_o & out_ready_i;
   assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_reg];
   always_ff @(posedge clock_i)
   begin
      if (push)
         mem_reg[wr_reg] <= in_data_i;
   end
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else if (flush_i)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: sim/usie_sie_assertions.sv
// Concurrent checks on the serial interface engine ports
`timescale 1ns/1ps
module usie_sie_assertions
   import usie_pkg::*;
#(
   parameter int NUM_EP = 9
) (
   // Clock and reset
   input wire logic          clock_i,
   input wire logic          arst_n_i,
   // Line drive
   input wire logic          dp_o,
   input wire logic          dm_o,
   input wire logic          line_oe_o,
   // Status and SRAM port
   input wire usie_token_t   token_o,
   input wire logic          token_pulse_o,
   input wire logic [10:0]   frame_o,
   input wire logic          sof_pulse_o,
   input wire logic          rx_done_o,
   input wire usie_ram_req_t ram_req_o,
   input wire logic          ram_req_valid_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);
   tok_pulse_one_a: assert property (token_pulse_o |=> !token_pulse_o)
      else $error("token pulse longer than one cycle");
   tok_kind_one_a: assert property (
      token_pulse_o |-> ##[0:1] $onehot({token_o.setup, token_o.in, token_o.out}))
      else $error("token kind not exactly one of three");
   tok_ep_range_a: assert property (token_pulse_o |-> ##[0:1] (token_o.ep < NUM_EP))
      else $error("token flagged for a missing endpoint");
   sof_pulse_one_a: assert property (sof_pulse_o |=> !sof_pulse_o)
      else $error("frame pulse longer than one cycle");
   frame_hold_a: assert property (
      $changed(frame_o) |-> (sof_pulse_o || $past(sof_pulse_o)))
      else $error("frame number moved without a frame packet");
   rx_done_one_a: assert property (rx_done_o |=> !rx_done_o)
      else $error("receive done longer than one cycle");
   tx_no_se1_a: assert property (line_oe_o |-> !(dp_o && dm_o))
      else $error("both line halves driven high");
   tx_span_a: assert property ($rose(line_oe_o) |-> line_oe_o[*8] ##[24:1000] !line_oe_o)
      else $error("reply length out of bounds");
   eop_ends_j_a: assert property ($fell(line_oe_o) |-> $past(dp_o && !dm_o))
      else $error("driver released before idle state");
   ram_wr_rx_a: assert property ((ram_req_valid_o && ram_req_o.we) |-> !line_oe_o)
      else $error("payload write while transmitting");
endmodule
bind usie_sie usie_sie_assertions #(.NUM_EP(NUM_EP)) chk_u (
   .clock_i(clock_i), .arst_n_i(arst_n_i), .dp_o(dp_o), .dm_o(dm_o),
   .line_oe_o(line_oe_o), .token_o(token_o), .token_pulse_o(token_pulse_o),
   .frame_o(frame_o), .sof_pulse_o(sof_pulse_o), .rx_done_o(rx_done_o),
   .ram_req_o(ram_req_o), .ram_req_valid_o(ram_req_valid_o));

// file: sim/usie_host_model.sv
// Host model: sends full-speed packets and decodes the short reply
`timescale 1ns/1ps
`include "usie_consts.svh"
module usie_host_model (
   // Clock and bus view
   input  wire logic clock_i,
   input  wire logic dp_i,
   input  wire logic line_oe_i,
   // Host drive, idle J
   output logic      dp_o,
   output logic      dm_o
);
   logic [7:0] pkt [$];
   logic       lvl;
   logic [7:0] rep_pid;
   logic       rep_prev;
   int         rep_pos = 0;
   // Reply decoder: locks on the first K of the reply, then samples each bit
   always @(posedge clock_i)
   begin
      if (!line_oe_i)
         rep_pos = 0;
      else if (rep_pos == 0)
      begin
         if (!dp_i)
         begin
            rep_pos = 1;
            rep_prev = 1'b0;
            rep_pid = 8'h00;
         end
      end
      else
      begin
         rep_pos++;
         if (rep_pos % 2 == 1)
         begin
            if (rep_pos >= 17 && rep_pos <= 31)
               rep_pid[(rep_pos - 17) / 2] = (dp_i == rep_prev);
            rep_prev = dp_i;
         end
      end
   end
   initial
   begin
      dp_o = 1'b1;
      dm_o = 1'b0;
      lvl = 1'b1;
   end
   function automatic logic [4:0] crc5(input logic [10:0] d);
      logic [4:0] c;
      c = 5'h1F;
      for (int i = 0; i < 11; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 5'h14 : 5'h00);
      return ~c;
   endfunction
   task automatic put_bit(input logic b);
      if (!b) lvl = ~lvl;
      dp_o = lvl;
      dm_o = ~lvl;
      repeat (2) @(posedge clock_i);
      #1;
   endtask
   task automatic send();
      int ones;
      ones = 0;
      rep_pid = 8'h00;
      pkt.push_front(`USIE_SYNC);
      foreach (pkt[j])
         for (int i = 0; i < 8; i++)
         begin
            put_bit(pkt[j][i]);
            ones = pkt[j][i] ? ones + 1 : 0;
            if (ones == 6)
            begin
               put_bit(1'b0);
               ones = 0;
            end
         end
      {dp_o, dm_o} = 2'b00;
      repeat (4) @(posedge clock_i);
      #1;
      {dp_o, dm_o} = 2'b10;
      lvl = 1'b1;
      repeat (4) @(posedge clock_i);
      #1;
   endtask
   task automatic token(input logic [3:0] pid, input logic [10:0] d, input logic bad);
      logic [4:0] c;
      c = crc5(d) ^ {4'h0, bad};
      pkt = '{{~pid, pid}, d[7:0], {c, d[10:8]}};
      send();
   endtask
   task automatic data(input logic [3:0] pid, input int n, input logic bad);
      logic [15:0] c;
      c = 16'hFFFF;
      pkt = '{{~pid, pid}};
      for (int k = 0; k < n; k++)
      begin
         pkt.push_back(8'h10 + 8'(k));
         for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ pkt[k+1][i]) ? 16'hA001 : 16'h0000);
      end
      c = ~c ^ {15'h0, bad};
      pkt.push_back(c[7:0]);
      pkt.push_back(c[15:8]);
      send();
   endtask
   // Reads SYNC and PID only; a silent device gives 8'h00
   task automatic recv(output logic [7:0] pid);
      int w;
      for (w = 0; !line_oe_i && w < 100; w++) @(posedge clock_i) #1;
      for (w = 0; line_oe_i && w < 2000; w++) @(posedge clock_i) #1;
      pid = rep_pid;
      repeat (4) @(posedge clock_i);
      #1;
   endtask
endmodule

// file: sim/usie_sie_tb_top.sv
// Self-checking bench for the USB serial interface engine
`timescale 1ns/1ps
`include "usie_consts.svh"
module usie_sie_tb_top;
   import usie_pkg::*;
   localparam logic [6:0] DEV_ADDR = 7'h2B;
   logic clock_i, arst_n_i, d_dp, d_dm, line_oe, tpul, spul, rxd, rvalid, h_dp, h_dm;
   logic [8:0]    ep_in, ep_rdy, ep_stl;
   logic [10:0]   frame;
   logic [6:0]    rx_len;
   usie_token_t   tok;
   usie_ram_req_t rreq;
   usie_ram_req_t wr_q [$];
   int            tok_cnt = 0, sof_cnt = 0, rxd_cnt = 0, error_cnt = 0, comparisons = 0;
   wire           bus_dp = line_oe ? d_dp : h_dp;
   wire           bus_dm = line_oe ? d_dm : h_dm;
   usie_sie dut_u (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .dp_i(bus_dp), .dm_i(bus_dm),
      .dp_o(d_dp), .dm_o(d_dm), .line_oe_o(line_oe), .dev_addr_i(DEV_ADDR),
      .ep_is_in_i(ep_in), .ep_ready_i(ep_rdy), .ep_stall_i(ep_stl), .ep_tx_len_i(7'h04),
      .token_o(tok), .token_pulse_o(tpul), .frame_o(frame), .sof_pulse_o(spul),
      .rx_len_o(rx_len), .rx_done_o(rxd), .ram_req_o(rreq), .ram_req_valid_o(rvalid),
      .ram_grant_i(rvalid), .ram_rdata_i(rreq.addr[7:0]));
   usie_host_model host_u (
      .clock_i(clock_i), .dp_i(bus_dp), .line_oe_i(line_oe), .dp_o(h_dp), .dm_o(h_dm));
   ////////////////////////////////////////
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      if (tpul) tok_cnt++;
      if (spul) sof_cnt++;
      if (rxd) rxd_cnt++;
      if (rvalid && rreq.we) wr_q.push_back(rreq);
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] pb(input logic [3:0] p);
      return {~p, p};
   endfunction
   task automatic xfer(input logic [3:0] pid, input logic [6:0] adr, input logic [3:0] ep,
                       input logic [1:0] bad, output logic [7:0] rep, output int pul);
      int t0;
      t0 = tok_cnt;
      host_u.token(pid, {ep, adr}, bad[0]);
      if (pid != `USIE_PID_IN) host_u.data(`USIE_PID_DATA0, 3, bad[1]);
      host_u.recv(rep);
      pul = tok_cnt - t0;
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      check({line_oe, d_dp, d_dm, tpul}, 16'h0004);
   endtask
   task automatic t_tokens();
      logic [3:0] pids [5] = '{`USIE_PID_SETUP, `USIE_PID_OUT, `USIE_PID_OUT,
                               `USIE_PID_IN, `USIE_PID_IN};
      logic [3:0] eps [5] = '{4'h0, 4'h2, 4'h3, 4'h1, 4'h4};
      logic [3:0] reps [5] = '{`USIE_PID_ACK, `USIE_PID_NAK, `USIE_PID_STALL,
                               `USIE_PID_DATA0, `USIE_PID_NAK};
      logic [7:0] rep;
      int         pul;
      for (int k = 0; k < 5; k++)
      begin
         xfer(pids[k], DEV_ADDR, eps[k], 2'b00, rep, pul);
         check(16'(pul), 16'h0001);
         check({tok.setup, tok.in, tok.out, tok.ep}, {pids[k] == `USIE_PID_SETUP,
               pids[k] == `USIE_PID_IN, pids[k] == `USIE_PID_OUT, eps[k]});
         check(rep, pb(reps[k]));
      end
   endtask
   task automatic t_refuse();
      logic [6:0] adrs [5] = '{DEV_ADDR ^ 7'h01, DEV_ADDR, DEV_ADDR, DEV_ADDR, DEV_ADDR};
      logic [3:0] eps [5] = '{4'h0, 4'h0, 4'h1, 4'h9, 4'h0};
      logic [1:0] bads [5] = '{2'b00, 2'b01, 2'b00, 2'b00, 2'b10};
      logic [7:0] rep;
      int         pul, r0;
      for (int k = 0; k < 5; k++)
      begin
         r0 = rxd_cnt;
         xfer(`USIE_PID_OUT, adrs[k], eps[k], bads[k], rep, pul);
         check(16'(pul), {15'h0, k == 4});
         check(rep, 16'h0000);
         check(16'(rxd_cnt - r0), 16'h0000);
      end
   endtask
   task automatic t_sof();
      logic [10:0] fr [3] = '{11'h5A3, 11'h7FF, 11'h000};
      logic [7:0]  rep;
      int          s0;
      for (int k = 0; k < 4; k++)
      begin
         s0 = sof_cnt;
         host_u.token(`USIE_PID_SOF, (k < 3) ? fr[k] : 11'h123, k == 3);
         host_u.recv(rep);
         check(16'(sof_cnt - s0), {15'h0, k < 3});
         check(frame, (k < 3) ? fr[k] : 11'h000);
      end
   endtask
   task automatic t_ram();
      logic [7:0] rep;
      int         pul, r0;
      wr_q.delete();
      r0 = rxd_cnt;
      xfer(`USIE_PID_OUT, DEV_ADDR, 4'h5, 2'b00, rep, pul);
      check(rep, pb(`USIE_PID_ACK));
      check({9'(rxd_cnt - r0), rx_len}, {9'h1, 7'h03});
      check(16'(wr_q.size()), 16'h0003);
      for (int k = 0; k < wr_q.size(); k++)
         check({wr_q[k].addr, wr_q[k].wdata}, {9'h140 + 9'(k), 8'h10 + 8'(k)});
   endtask
   task automatic close_out();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      arst_n_i = 1'b0;
      ep_in = 9'h012;
      ep_rdy = 9'h023;
      ep_stl = 9'h008;
      repeat (8) @(posedge clock_i);
      #1 arst_n_i = 1'b1;
      t_reset();
      t_tokens();
      t_refuse();
      t_sof();
      t_ram();
      close_out();
   end
   initial
   begin
      #600000;
      error_cnt++;
      close_out();
   end
endmodule
